// ===== ipm_indicator_pin_mux.sv
// Register file and output selection for the four multi-function indicator pins.
`default_nettype none
module ipm_indicator_pin_mux (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address channel.
    input wire logic [ipm_pkg::IPM_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data channel.
    input wire logic [ipm_pkg::IPM_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response channel.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address channel.
    input wire logic [ipm_pkg::IPM_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data channel.
    output logic [ipm_pkg::IPM_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Strap pins, sampled after reset release.
    input wire logic strap_enhanced_mode,
    input wire logic strap_rmii_valid_pin_flavour,
    input wire logic strap_reference_clock_output_sel,
    // Function sources from the rest of the transceiver.
    input wire logic [ipm_pkg::IPM_PINS-1:0] link_indicator,
    input wire logic pll_clock,
    input wire logic recovered_clock,
    input wire logic reference_clock,
    input wire logic wake_event_output,
    input wire logic interrupt_event,
    input wire logic mii_tx_er,
    input wire logic mii_col,
    input wire logic mii_crs,
    // Pins and configuration outputs.
    output logic indicator_pin_a,
    output logic indicator_pin_b,
    output logic indicator_pin_c,
    output logic indicator_pin_d,
    output logic rmii_valid_pin_flavour,
    output logic [1:0] mac_pin_termination_speed,
    output logic ref_clock_pin_state,
    output logic common_pin_mode
);
    import ipm_pkg::*;

    // ------------------------------------------------------------------
    // Strap synchronisers and one-time load after reset release
    // ------------------------------------------------------------------
    logic [2:0] strap_meta_q;
    logic [2:0] strap_sync_q;
    logic [1:0] strap_cnt_q;
    logic [1:0] strap_cnt_d;
    logic enhanced_q;
    logic enhanced_d;
    logic strap_load;

    always_ff @(posedge aclk) begin
        strap_meta_q <= {strap_reference_clock_output_sel, strap_rmii_valid_pin_flavour, strap_enhanced_mode};
        strap_sync_q <= strap_meta_q;
    end

    always_comb begin
        strap_load = (strap_cnt_q == IPM_STRAP_LOAD_CNT);
        strap_cnt_d = strap_cnt_q;
        if (strap_cnt_q != IPM_STRAP_DONE_CNT) begin
            strap_cnt_d = strap_cnt_q + 2'h1;
        end
        enhanced_d = enhanced_q;
        if (strap_load) begin
            enhanced_d = strap_sync_q[0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            strap_cnt_q <= 2'h0;
            enhanced_q <= 1'b0;
        end else begin
            strap_cnt_q <= strap_cnt_d;
            enhanced_q <= enhanced_d;
        end
    end

    // ------------------------------------------------------------------
    // AXI4-Lite write path
    // ------------------------------------------------------------------
    ipm_wr_state_t wr_state_q;
    ipm_wr_state_t wr_state_d;
    logic [IPM_IDX_W-1:0] wr_idx_q;
    logic [IPM_IDX_W-1:0] wr_idx_d;
    logic [IPM_REG_W-1:0] wr_data_q;
    logic [IPM_REG_W-1:0] wr_data_d;
    logic [1:0] wr_strb_q;
    logic [1:0] wr_strb_d;
    logic [1:0] bresp_q;
    logic [1:0] bresp_d;
    logic aw_take;
    logic w_take;
    logic wr_commit;
    logic [IPM_REG_W-1:0] wr_bytes;

    always_comb begin
        s_axi_awready = (wr_state_q == IPM_WS_IDLE) || (wr_state_q == IPM_WS_HAVE_DATA);
        s_axi_wready = (wr_state_q == IPM_WS_IDLE) || (wr_state_q == IPM_WS_HAVE_ADDR);
        aw_take = s_axi_awvalid && s_axi_awready;
        w_take = s_axi_wvalid && s_axi_wready;
        wr_idx_d = wr_idx_q;
        wr_data_d = wr_data_q;
        wr_strb_d = wr_strb_q;
        bresp_d = bresp_q;
        wr_state_d = wr_state_q;
        wr_commit = 1'b0;
        if (aw_take) begin
            wr_idx_d = s_axi_awaddr[IPM_IDX_LSB +: IPM_IDX_W];
        end
        if (w_take) begin
            wr_data_d = s_axi_wdata[IPM_REG_W-1:0];
            wr_strb_d = s_axi_wstrb[1:0];
        end
        case (wr_state_q)
            IPM_WS_IDLE: begin
                if (aw_take && w_take) begin
                    wr_state_d = IPM_WS_RESP;
                    wr_commit = 1'b1;
                end else if (aw_take) begin
                    wr_state_d = IPM_WS_HAVE_ADDR;
                end else if (w_take) begin
                    wr_state_d = IPM_WS_HAVE_DATA;
                end
            end
            IPM_WS_HAVE_ADDR: begin
                if (w_take) begin
                    wr_state_d = IPM_WS_RESP;
                    wr_commit = 1'b1;
                end
            end
            IPM_WS_HAVE_DATA: begin
                if (aw_take) begin
                    wr_state_d = IPM_WS_RESP;
                    wr_commit = 1'b1;
                end
            end
            IPM_WS_RESP: begin
                if (s_axi_bready) begin
                    wr_state_d = IPM_WS_IDLE;
                end
            end
            default: begin
                wr_state_d = IPM_WS_IDLE;
            end
        endcase
        if (wr_commit) begin
            bresp_d = idx_mapped(wr_idx_d) ? IPM_RESP_OKAY : IPM_RESP_SLVERR;
        end
        wr_bytes = {{8{wr_strb_d[1]}}, {8{wr_strb_d[0]}}};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state_q <= IPM_WS_IDLE;
            wr_idx_q <= '0;
            wr_data_q <= '0;
            wr_strb_q <= 2'h0;
            bresp_q <= IPM_RESP_OKAY;
        end else begin
            wr_state_q <= wr_state_d;
            wr_idx_q <= wr_idx_d;
            wr_data_q <= wr_data_d;
            wr_strb_q <= wr_strb_d;
            bresp_q <= bresp_d;
        end
    end

    assign s_axi_bvalid = (wr_state_q == IPM_WS_RESP);
    assign s_axi_bresp = bresp_q;

    function automatic logic idx_mapped(input logic [IPM_IDX_W-1:0] idx);
        idx_mapped = (idx == IPM_IDX_PIN_IO_CONFIG_MAIN) || (idx == IPM_IDX_CLOCK_OUTPUT_STATUS)
            || ((idx >= IPM_IDX_INDICATOR_A_FUNCTION_CFG) && (idx <= IPM_IDX_INDICATOR_D_FUNCTION_CFG));
    endfunction

    function automatic logic [IPM_REG_W-1:0] merge(input logic [IPM_REG_W-1:0] old_val,
                                                   input logic [IPM_REG_W-1:0] new_val,
                                                   input logic [IPM_REG_W-1:0] mask);
        merge = (old_val & ~mask) | (new_val & mask);
    endfunction

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [IPM_REG_W-1:0] io_cfg_q;
    logic [IPM_REG_W-1:0] io_cfg_d;
    logic [IPM_REG_W-1:0] ind_cfg_q [IPM_PINS];
    logic [IPM_REG_W-1:0] ind_cfg_d [IPM_PINS];
    logic [IPM_REG_W-1:0] clk_stat_q;
    logic [IPM_REG_W-1:0] clk_stat_d;
    logic ref_state;

    always_comb begin
        io_cfg_d = io_cfg_q;
        clk_stat_d = clk_stat_q;
        if (strap_load) begin
            io_cfg_d[IPM_RMII_FLAVOUR_BIT] = strap_sync_q[1];
        end
        if (wr_commit && (wr_idx_d == IPM_IDX_PIN_IO_CONFIG_MAIN)) begin
            io_cfg_d = merge(io_cfg_q, wr_data_d, IPM_WMASK_PIN_IO_CONFIG_MAIN & wr_bytes);
        end
        if (wr_commit && (wr_idx_d == IPM_IDX_CLOCK_OUTPUT_STATUS)) begin
            clk_stat_d = merge(clk_stat_q, wr_data_d, IPM_WMASK_CLOCK_OUTPUT_STATUS & wr_bytes);
        end
    end

    for (genvar p = 0; p < IPM_PINS; p++) begin : g_cfg
        always_comb begin
            ind_cfg_d[p] = ind_cfg_q[p];
            if ((p == 1) && strap_load && strap_sync_q[0] && strap_sync_q[2]) begin
                ind_cfg_d[p][IPM_FUNC_MSB:IPM_FUNC_LSB] = IPM_FUNC_B_REF_CLOCK;
            end
            if (wr_commit && (wr_idx_d == IPM_IDX_INDICATOR_A_FUNCTION_CFG + IPM_IDX_W'(p))) begin
                ind_cfg_d[p] = merge(ind_cfg_q[p], wr_data_d, IPM_WMASK_INDICATOR_CFG & wr_bytes);
            end
        end
        always_ff @(posedge aclk) begin
            if (!aresetn) begin
                ind_cfg_q[p] <= IPM_RST_INDICATOR_CFG;
            end else begin
                ind_cfg_q[p] <= ind_cfg_d[p];
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            io_cfg_q <= IPM_RST_PIN_IO_CONFIG_MAIN;
            clk_stat_q <= IPM_RST_CLOCK_OUTPUT_STATUS;
        end else begin
            io_cfg_q <= io_cfg_d;
            clk_stat_q <= clk_stat_d;
        end
    end

    // Status is only meaningful in enhanced mode and reads 0 otherwise.
    assign ref_state = enhanced_q && io_cfg_q[IPM_REF_CLK_DISABLE_BIT];

    // ------------------------------------------------------------------
    // AXI4-Lite read path
    // ------------------------------------------------------------------
    logic rvalid_q;
    logic rvalid_d;
    logic [IPM_REG_W-1:0] rdata_q;
    logic [IPM_REG_W-1:0] rdata_d;
    logic [1:0] rresp_q;
    logic [1:0] rresp_d;
    logic [IPM_IDX_W-1:0] rd_idx;

    always_comb begin
        s_axi_arready = !rvalid_q;
        rd_idx = s_axi_araddr[IPM_IDX_LSB +: IPM_IDX_W];
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = idx_mapped(rd_idx) ? IPM_RESP_OKAY : IPM_RESP_SLVERR;
            rdata_d = '0;
            case (rd_idx)
                IPM_IDX_PIN_IO_CONFIG_MAIN: rdata_d = io_cfg_q;
                IPM_IDX_INDICATOR_A_FUNCTION_CFG: rdata_d = ind_cfg_q[0];
                IPM_IDX_INDICATOR_B_FUNCTION_CFG: rdata_d = ind_cfg_q[1];
                IPM_IDX_INDICATOR_C_FUNCTION_CFG: rdata_d = ind_cfg_q[2];
                IPM_IDX_INDICATOR_D_FUNCTION_CFG: rdata_d = ind_cfg_q[3];
                IPM_IDX_CLOCK_OUTPUT_STATUS: begin
                    rdata_d = clk_stat_q;
                    rdata_d[IPM_REF_CLK_STATE_BIT] = ref_state;
                end
                default: rdata_d = '0;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= IPM_RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = {{(IPM_DATA_W-IPM_REG_W){1'b0}}, rdata_q};
    assign s_axi_rresp = rresp_q;

    // ------------------------------------------------------------------
    // Pin source selection
    // ------------------------------------------------------------------
    logic [2:0] clk_sel [IPM_PINS];
    logic sel_clock [IPM_PINS];
    logic [7:0] pin_sources [IPM_PINS];
    logic [IPM_PINS-1:0] pin_level;

    for (genvar p = 0; p < IPM_PINS; p++) begin : g_pin
        assign clk_sel[p] = ind_cfg_q[p][IPM_CLK_SEL_MSB:IPM_CLK_SEL_LSB];
        // Reserved clock codes give a steady low rather than a floating pin.
        assign sel_clock[p] = (clk_sel[p] == IPM_CLK_SEL_PLL) ? pll_clock :
                              (clk_sel[p] == IPM_CLK_SEL_RECOVERED) ? recovered_clock : 1'b0;
        ipm_src_mux u_mux (
            .sources(pin_sources[p]),
            .func_sel(ind_cfg_q[p][IPM_FUNC_MSB:IPM_FUNC_LSB]),
            .pin_out(pin_level[p])
        );
    end

    // Bit order is code 7 down to code 0.
    assign pin_sources[0] = {1'b1, 1'b0, 1'b0, interrupt_event, 1'b0, wake_event_output, sel_clock[0],
                             link_indicator[0]};
    assign pin_sources[1] = {1'b0, reference_clock, mii_tx_er, interrupt_event, 1'b0, wake_event_output,
                             sel_clock[1], link_indicator[1]};
    assign pin_sources[2] = {1'b1, mii_col, mii_col, interrupt_event, mii_col, wake_event_output, 1'b0,
                             link_indicator[2]};
    assign pin_sources[3] = {1'b1, mii_crs, mii_crs, interrupt_event, mii_crs, wake_event_output, 1'b0,
                             link_indicator[3]};

    assign indicator_pin_a = pin_level[0];
    // In enhanced mode the shared pin carries the reference clock unless the disable bit hands it back to the pin b function mux.
    assign indicator_pin_b = (enhanced_q && !io_cfg_q[IPM_REF_CLK_DISABLE_BIT]) ? reference_clock
                                                                                : pin_level[1];
    assign indicator_pin_c = pin_level[2];
    assign indicator_pin_d = pin_level[3];
    assign rmii_valid_pin_flavour = io_cfg_q[IPM_RMII_FLAVOUR_BIT];
    assign mac_pin_termination_speed = io_cfg_q[IPM_TERM_MSB:IPM_TERM_LSB];
    assign ref_clock_pin_state = ref_state;
    assign common_pin_mode = !enhanced_q;
endmodule // ipm_indicator_pin_mux
`default_nettype wire

// ===== ipm_pkg.sv
// Package with register map, field layout and reset values of the indicator pin function mux.
`default_nettype none
package ipm_pkg;
    // ------------------------------------------------------------------
    // Bus geometry
    // ------------------------------------------------------------------
    localparam int unsigned IPM_ADDR_W = 12;
    localparam int unsigned IPM_DATA_W = 32;
    localparam int unsigned IPM_REG_W = 16;
    localparam int unsigned IPM_IDX_W = 10;
    localparam int unsigned IPM_IDX_LSB = 2;
    localparam int unsigned IPM_PINS = 4;

    // ------------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [9:0] IPM_IDX_PIN_IO_CONFIG_MAIN = 10'h302;
    localparam logic [9:0] IPM_IDX_INDICATOR_A_FUNCTION_CFG = 10'h303;
    localparam logic [9:0] IPM_IDX_INDICATOR_B_FUNCTION_CFG = 10'h304;
    localparam logic [9:0] IPM_IDX_INDICATOR_C_FUNCTION_CFG = 10'h305;
    localparam logic [9:0] IPM_IDX_INDICATOR_D_FUNCTION_CFG = 10'h306;
    localparam logic [9:0] IPM_IDX_CLOCK_OUTPUT_STATUS = 10'h308;

    // ------------------------------------------------------------------
    // Reset values and writable masks
    // ------------------------------------------------------------------
    localparam logic [15:0] IPM_RST_PIN_IO_CONFIG_MAIN = 16'h0000;
    localparam logic [15:0] IPM_RST_INDICATOR_CFG = 16'h0008;
    localparam logic [15:0] IPM_RST_CLOCK_OUTPUT_STATUS = 16'h0002;
    localparam logic [15:0] IPM_WMASK_PIN_IO_CONFIG_MAIN = 16'hffc0;
    localparam logic [15:0] IPM_WMASK_INDICATOR_CFG = 16'h003f;
    localparam logic [15:0] IPM_WMASK_CLOCK_OUTPUT_STATUS = 16'hfffe;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int unsigned IPM_TERM_MSB = 15;
    localparam int unsigned IPM_TERM_LSB = 14;
    localparam int unsigned IPM_RMII_FLAVOUR_BIT = 8;
    localparam int unsigned IPM_REF_CLK_DISABLE_BIT = 6;
    localparam int unsigned IPM_REF_CLK_STATE_BIT = 0;
    localparam int unsigned IPM_CLK_SEL_MSB = 5;
    localparam int unsigned IPM_CLK_SEL_LSB = 3;
    localparam int unsigned IPM_FUNC_MSB = 2;
    localparam int unsigned IPM_FUNC_LSB = 0;

    // ------------------------------------------------------------------
    // Codes
    // ------------------------------------------------------------------
    localparam logic [2:0] IPM_CLK_SEL_PLL = 3'h5;
    localparam logic [2:0] IPM_CLK_SEL_RECOVERED = 3'h6;
    localparam logic [2:0] IPM_FUNC_B_REF_CLOCK = 3'h6;
    localparam logic [1:0] IPM_RESP_OKAY = 2'h0;
    localparam logic [1:0] IPM_RESP_SLVERR = 2'h2;

    // Edges counted since reset release after which synchronised straps are loaded, on the next edge.
    localparam logic [1:0] IPM_STRAP_LOAD_CNT = 2'h2;
    localparam logic [1:0] IPM_STRAP_DONE_CNT = 2'h3;

    typedef enum logic [1:0] {
        IPM_WS_IDLE = 2'b00,
        IPM_WS_HAVE_ADDR = 2'b01,
        IPM_WS_HAVE_DATA = 2'b10,
        IPM_WS_RESP = 2'b11
    } ipm_wr_state_t;
endpackage : ipm_pkg
`default_nettype wire

// ===== ipm_src_mux.sv
// Eight-way source selector that places one function source on an indicator pin.
`default_nettype none
module ipm_src_mux (
    // Candidate sources indexed by function code.
    input wire logic [7:0] sources,
    // Registered function code.
    input wire logic [2:0] func_sel,
    // Pin level.
    output logic pin_out
);
    always_comb begin
        pin_out = sources[func_sel];
    end
endmodule // ipm_src_mux
`default_nettype wire

// ===== ipm_lamp_load.sv
// Board-side lamp load on the four indicator pins.
`default_nettype none
module ipm_lamp_load (
    // Clock.
    input wire logic aclk,
    // Indicator pins, lamp lit while high.
    input wire logic [3:0] pins,
    // Level changes seen on any pin.
    output logic [15:0] edge_count
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] last_q = 4'h0;
    initial edge_count = 16'h0000;
    always @(posedge aclk) begin
        if (pins != last_q) begin
            edge_count <= edge_count + 16'h0001;
        end
        last_q <= pins;
    end
endmodule // ipm_lamp_load
`default_nettype wire

// ===== ipm_indicator_pin_mux_sva.sv
// Checker of bus handshakes and configuration outputs of the indicator pin mux.
`default_nettype none
module ipm_indicator_pin_mux_chk (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Bus handshakes.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pins and configuration outputs.
    input wire logic reference_clock,
    input wire logic indicator_pin_b,
    input wire logic rmii_valid_pin_flavour,
    input wire logic [1:0] mac_pin_termination_speed,
    input wire logic ref_clock_pin_state,
    input wire logic common_pin_mode
);
    // Counts edges since reset release so strap loading is left alone.
    logic [2:0] rel_cnt_q;
    logic [2:0] rel_cnt_d;
    always_comb begin
        rel_cnt_d = (rel_cnt_q == 3'h5) ? rel_cnt_q : rel_cnt_q + 3'h1;
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rel_cnt_q <= 3'h0;
        end else begin
            rel_cnt_q <= rel_cnt_d;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    chk_wr_resp_next: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |=> s_axi_bvalid) else $error("write response late");
    chk_rd_resp_next: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read response late");
    chk_rd_data_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_wr_resp_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    chk_wr_busy_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while busy");
    chk_term_on_write: assert property (rel_cnt_q == 3'h5 && !$stable(mac_pin_termination_speed)
        |-> $rose(s_axi_bvalid)) else $error("termination changed without write");
    chk_flavour_write: assert property (rel_cnt_q == 3'h5 && !$stable(rmii_valid_pin_flavour)
        |-> $rose(s_axi_bvalid)) else $error("flavour changed without write");
    chk_mode_steady: assert property (rel_cnt_q == 3'h5 |-> $stable(common_pin_mode))
        else $error("pin mode changed");
    chk_state_mode: assert property (ref_clock_pin_state |-> !common_pin_mode)
        else $error("state set outside enhanced mode");
    chk_pin_b_refclk: assert property (!common_pin_mode && !ref_clock_pin_state
        |-> indicator_pin_b == reference_clock) else $error("pin b not on reference clock");
endmodule // ipm_indicator_pin_mux_chk
bind ipm_indicator_pin_mux ipm_indicator_pin_mux_chk u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .reference_clock, .indicator_pin_b, .rmii_valid_pin_flavour,
    .mac_pin_termination_speed, .ref_clock_pin_state, .common_pin_mode);
`default_nettype wire

// ===== ipm_indicator_pin_mux_bench.sv
// Self-checking bench of the indicator pin mux against a register and pin model.
`default_nettype none
module ipm_indicator_pin_mux_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import ipm_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid, rmii, state, common, pin_a, pin_b, pin_c, pin_d;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000, src = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, term;
    logic [2:0] straps = 3'h0;
    logic [15:0] lfsr_q = 16'h000b, edges;
    int num_errors = 0, cmp_count = 0, cycles = 0, enh = 0;
    int rm[6];
    always #20 aclk = ~aclk;
    ipm_indicator_pin_mux DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .strap_rmii_valid_pin_flavour(straps[0]), .strap_enhanced_mode(straps[1]),
        .strap_reference_clock_output_sel(straps[2]), .link_indicator(src[3:0]), .pll_clock(src[4]),
        .recovered_clock(src[5]), .reference_clock(src[6]), .wake_event_output(src[7]), .interrupt_event(src[8]),
        .mii_tx_er(src[9]), .mii_col(src[10]), .mii_crs(src[11]), .indicator_pin_a(pin_a), .indicator_pin_b(pin_b),
        .indicator_pin_c(pin_c), .indicator_pin_d(pin_d), .rmii_valid_pin_flavour(rmii),
        .mac_pin_termination_speed(term), .ref_clock_pin_state(state), .common_pin_mode(common));
    ipm_lamp_load u_load (.aclk, .pins({pin_d, pin_c, pin_b, pin_a}), .edge_count(edges));
    // ----------------------------------------------------------------
    // Model and helpers
    // ----------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    function automatic int pos(int idx);
        if (idx >= 'h302 && idx <= 'h306) return idx - 'h302;
        return (idx == 'h308) ? 5 : -1;
    endfunction
    function automatic int exp_pin(int p, int s);
        int f;
        int cs;
        f = rm[p + 1] & 7;
        cs = (rm[p + 1] >> 3) & 7;
        if (p == 1 && enh != 0 && ((rm[0] >> 6) & 1) == 0) return (s >> 6) & 1;
        if (f == 0) return (s >> p) & 1;
        if (f == 1) return (p > 1) ? 0 : (cs == 5) ? (s >> 4) & 1 : (cs == 6) ? (s >> 5) & 1 : 0;
        if (f == 2) return (s >> 7) & 1;
        if (f == 4) return (s >> 8) & 1;
        if (f == 7) return (p == 1) ? 0 : 1;
        if (p == 1) return (f == 5) ? (s >> 9) & 1 : (f == 6) ? (s >> 6) & 1 : 0;
        return (p == 0) ? 0 : (s >> (8 + p)) & 1;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input int idx, input logic [31:0] d);
        int p;
        int m;
        p = pos(idx);
        s_axi_awaddr <= 12'(idx * 4);
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        chk(32'(s_axi_bresp), (p < 0) ? 2 : 0, "write response");
        s_axi_bready <= 1'b0;
        m = (p == 0) ? 'hffc0 : (p == 5) ? 'hfffe : 'h003f;
        if (p >= 0) rm[p] = (rm[p] & ~m) | (d & m);
        @(posedge aclk);
    endtask
    task automatic rd(input int idx);
        int p;
        p = pos(idx);
        s_axi_araddr <= 12'(idx * 4);
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        forever begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        chk(32'(s_axi_rresp), (p < 0) ? 2 : 0, "read response");
        chk(s_axi_rdata, (p < 0) ? 0 : (p == 5) ? (rm[5] | (enh & (rm[0] >> 6))) : rm[p], "read data");
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic pins_check();
        logic [3:0] got;
        repeat (4) begin
            lfsr_q = lfsr(lfsr_q);
            src <= lfsr_q[11:0];
            @(negedge aclk);
            got = {pin_d, pin_c, pin_b, pin_a};
            for (int p = 0; p < 4; p++) chk(32'(got[p]), exp_pin(p, int'(lfsr_q[11:0])), "pin level");
            chk(32'(term), (rm[0] >> 14) & 3, "termination");
            chk(32'(rmii), (rm[0] >> 8) & 1, "rmii flavour");
            chk(32'({state, common}), {enh & (rm[0] >> 6), !enh}, "pin mode state");
            @(posedge aclk);
        end
    endtask
    task automatic do_reset(input logic [2:0] st);
        straps <= st;
        aresetn <= 1'b0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (4) @(posedge aclk);
        enh = st[1];
        rm = '{(st[0] ? 'h100 : 0), 8, ((st[1] && st[2]) ? 'he : 8), 8, 8, 2};
        for (int p = 0; p < 6; p++) rd((p < 5) ? 'h302 + p : 'h308);
        pins_check();
    endtask
    task automatic wrap_up();
        $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge aclk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            wrap_up();
        end
    end
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    initial begin
        do_reset(3'b001);
        rd('h307);
        wr('h309, 32'hffff);
        $display("Reset values and unmapped access done");
        for (int p = 1; p < 5; p++) begin
            for (int k = 0; k < 24; k++) begin
                lfsr_q = lfsr(lfsr_q);
                wr('h302 + p, {lfsr_q, lfsr_q[9:0], 3'((k < 8) ? 5 : (k < 16) ? 6 : 2), 3'(k)});
                rd('h302 + p);
                pins_check();
            end
        end
        chk(32'(edges != 16'h0), 1, "lamp activity");
        $display("Function sweep done");
        wr('h302, 32'hffff_ffff);
        rd('h302);
        pins_check();
        wr('h302, 32'h0000_4000);
        wr('h308, 32'h0000_ffff);
        rd('h308);
        pins_check();
        $display("Io configuration done");
        do_reset(3'b110);
        wr('h302, 32'h0000_0040);
        rd('h308);
        pins_check();
        wr('h304, 32'h0000_0002);
        pins_check();
        wr('h302, 32'h0000_0000);
        rd('h308);
        pins_check();
        $display("Enhanced mode done");
        wrap_up();
    end
endmodule // ipm_indicator_pin_mux_bench
`default_nettype wire
